// >>> common/wwdrf_pkg.sv
package wwdrf_pkg;

    // ************************************************************
    // Register map (register index, byte address is index times 4)
    // ************************************************************
    localparam int IDX_CFG      = 'h807;
    localparam int IDX_CTRL_A   = 'h80c;
    localparam int IDX_CTRL_B   = 'h80d;
    localparam int IDX_STATUS   = 'h810;
    localparam int IDX_FLAGS    = 'h813;
    localparam int IDX_MEM_VIOLATION_N     = 'h814;
    localparam logic [13:0] ADDR_CFG    = 14'(IDX_CFG * 4);
    localparam logic [13:0] ADDR_CTRL_A = 14'(IDX_CTRL_A * 4);
    localparam logic [13:0] ADDR_CTRL_B = 14'(IDX_CTRL_B * 4);
    localparam logic [13:0] ADDR_STATUS = 14'(IDX_STATUS * 4);
    localparam logic [13:0] ADDR_FLAGS  = 14'(IDX_FLAGS * 4);
    localparam logic [13:0] ADDR_MEM_VIOLATION_N   = 14'(IDX_MEM_VIOLATION_N * 4);

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int B_STK_OVF = 7;
    localparam int B_STK_UNF = 6;
    localparam int B_WIN_VIO = 5;
    localparam int B_TIMEOUT = 4;
    localparam int B_PIN_RST = 3;
    localparam int B_SOFT    = 2;
    localparam int B_POR     = 1;
    localparam int B_BROWN   = 0;
    localparam int B_MEM_VIOLATION_N    = 1;

    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [7:0] FLAGS_RST       = 8'h3d;
    localparam logic [4:0] PS_ALL_ONES     = 5'h1f;
    localparam logic [4:0] PS_DEFAULT      = 5'h0b;
    localparam logic [4:0] PS_MAX          = 5'h12;
    localparam logic [2:0] WIN_FULL        = 3'h7;
    localparam logic [2:0] CLK_MID         = 3'h1;
    localparam logic [1:0] MODE_ON         = 2'h3;
    localparam logic [1:0] MODE_AWAKE      = 2'h2;
    localparam logic [1:0] MODE_SOFT       = 2'h1;
    localparam logic [1:0] CFG_MODE_RST    = 2'h3;
    localparam logic [2:0] CFG_CLK_RST     = 3'h0;
    localparam logic [4:0] PS_BASE_SHIFT   = 5'h05;
    localparam logic [4:0] PS_EIGHTH_SHIFT = 5'h02;

    // ************************************************************
    // Time base
    // ************************************************************
    localparam int CLK_HZ        = 125_000_000;
    localparam int LOW_OSC_HZ    = 31_000;
    localparam int MID_OSC_HZ    = 31_250;
    localparam logic [11:0] LOW_TICK_CYCLES = 12'(CLK_HZ / LOW_OSC_HZ);
    localparam logic [11:0] MID_TICK_CYCLES = 12'(CLK_HZ / MID_OSC_HZ);

    typedef struct packed {
        logic stack_over;
        logic stack_under;
        logic pin_reset;
        logic soft_reset;
        logic power_on;
        logic brown_out;
        logic mem_violation;
        logic dog_clear_instr;
        logic sleep;
        logic wake_int;
        logic ost_running;
    } wwdrf_evt_t;

endpackage

// >>> core/wwdrf_core.sv
`timescale 1ns/1ns
//Behaviour
// - Stack overflow event sets flag bit 7; firmware clears; power-on/brown-out clear it.
// - Stack underflow event sets flag bit 6; firmware clears; power-on/brown-out clear it.
// - Window violation reset clears bit 5; power-on or firmware one sets it.
// - Timeout reset clears bit 4; power-on, brown-out or firmware one set it.
// - Master clear pin reset clears bit 3; power-on, brown-out or firmware set it.
// - Reset instruction clears bit 2; power-on, brown-out or firmware set it.
// - Power-on reset clears bit 1; other resets leave it; firmware may set.
// - Brown-out reset clears bit 0; other resets leave it; firmware may set.
// - Memory violation clears second register bit 1; power-on/brown-out set it.
// - Missing clear within timeout period resets the device.
// - Time base is the 31 kHz or 31.25 kHz oscillator.
// - Mode upper bit set: clock source comes from configuration select.
// - Mode 01: software enable runs the dog, runtime clock select used.
// - Mode 11 always on, 10 off in sleep, 01 soft, 00 off.
// - Config period all ones: runtime prescale picks 1 ms to 256 s.
// - After any reset the default period is nominally 2 s when the config period is all ones.
// - Clear outside open window is a violation and resets.
// - Runtime window used only when config window equals 111.
// - Window open decided from counter against window boundary.
// - Dog cleared on resets, clears, sleep entry, wake interrupts, disable, OST, control writes.
// - Windowed clear needs a prior read of control A, else violation.
// - Timeout in sleep wakes instead of reset and updates TO/PD.
module wwdrf_core
    import wwdrf_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic [13:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire wwdrf_evt_t  i_evt,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_dog_reset,
    output logic             o_dog_wake,
    output logic             o_timeout_n,
    output logic             o_powerdown_n
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0]  flags;
        logic        mem_ok;
        logic [1:0]  cfg_mode;
        logic [2:0]  cfg_clk;
        logic [4:0]  cfg_ps;
        logic [2:0]  cfg_win;
        logic [4:0]  rt_ps;
        logic        soft_en;
        logic [2:0]  rt_clk;
        logic [2:0]  rt_win;
        logic [11:0] presc;
        logic [23:0] cnt;
        logic        armed;
        logic        sleep_d;
        logic        dog_reset;
        logic        dog_wake;
        logic        to_n;
        logic        pd_n;
        logic        waitreq;
        logic [7:0]  rdata;
    } wwdrf_state_t;

    localparam wwdrf_state_t STATE_RST = '{
        flags: FLAGS_RST, mem_ok: 1'b1, cfg_mode: CFG_MODE_RST, cfg_clk: CFG_CLK_RST,
        cfg_ps: PS_ALL_ONES, cfg_win: WIN_FULL, rt_ps: PS_DEFAULT, soft_en: 1'b0,
        rt_clk: CFG_CLK_RST, rt_win: WIN_FULL, presc: 12'h000, cnt: 24'h000000,
        armed: 1'b0, sleep_d: 1'b0, dog_reset: 1'b0, dog_wake: 1'b0, to_n: 1'b1,
        pd_n: 1'b1, waitreq: 1'b1, rdata: 8'h00};

    wwdrf_state_t s_reg;
    wwdrf_state_t s_next;

    // ************************************************************
    // Derived watchdog controls
    // ************************************************************
    logic        running;
    logic [2:0]  clk_sel;
    logic [4:0]  ps_raw;
    logic [4:0]  ps;
    logic [2:0]  win;
    logic        windowed;
    logic [23:0] limit;
    logic [2:0]  eighth;
    logic        win_open;
    logic [11:0] tick_max;
    logic        tick;
    logic        timeout;
    logic        violation;
    logic        valid_clear;
    logic        any_ext_reset;
    logic        rd_fire;
    logic        wr_fire;
    logic        ctrl_write;

    assign running = (s_reg.cfg_mode == MODE_ON)
                   | (s_reg.cfg_mode == MODE_AWAKE & ~i_evt.sleep)
                   | (s_reg.cfg_mode == MODE_SOFT & s_reg.soft_en);
    assign clk_sel = s_reg.cfg_mode[1] ? s_reg.cfg_clk : s_reg.rt_clk;
    assign tick_max = (clk_sel == CLK_MID) ? MID_TICK_CYCLES - 12'h001
                                           : LOW_TICK_CYCLES - 12'h001;
    assign ps_raw = (s_reg.cfg_ps == PS_ALL_ONES) ? s_reg.rt_ps : s_reg.cfg_ps;
    // Reserved codes fall back to the shortest interval
    assign ps = (ps_raw > PS_MAX) ? 5'h00 : ps_raw;
    assign limit = 24'h000001 << (ps + PS_BASE_SHIFT);
    assign eighth = 3'(s_reg.cnt >> (ps + PS_EIGHTH_SHIFT));
    assign win = (s_reg.cfg_win == WIN_FULL) ? s_reg.rt_win : s_reg.cfg_win;
    assign windowed = (win != WIN_FULL);
    assign win_open = ~windowed | (eighth >= (WIN_FULL - win));
    assign tick = running & (s_reg.presc == tick_max);
    assign timeout = tick & (s_reg.cnt == limit - 24'h000001);
    assign violation = running & i_evt.dog_clear_instr & windowed
                     & (~s_reg.armed | ~win_open);
    assign valid_clear = i_evt.dog_clear_instr & ~violation;
    assign any_ext_reset = i_evt.pin_reset | i_evt.soft_reset | i_evt.power_on
                         | i_evt.brown_out | i_evt.mem_violation;
    assign rd_fire = i_avs_read & ~s_reg.waitreq;
    assign wr_fire = i_avs_write & ~s_reg.waitreq & i_avs_byteenable[0];
    assign ctrl_write = wr_fire & (i_avs_address == ADDR_CTRL_A | i_avs_address == ADDR_CTRL_B);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic dog_clear;
        logic sleep_rise;
        logic own_reset;
        dog_clear = 1'b0;
        sleep_rise = i_evt.sleep & ~s_reg.sleep_d;
        own_reset = (timeout & ~i_evt.sleep) | violation;
        s_next = s_reg;
        s_next.dog_reset = 1'b0;
        s_next.dog_wake = 1'b0;
        s_next.sleep_d = i_evt.sleep;

        // One wait state: request seen, answer on the next edge
        if ((i_avs_read | i_avs_write) & s_reg.waitreq) begin
            s_next.waitreq = 1'b0;
            case (i_avs_address)
                ADDR_CFG:    s_next.rdata = {s_reg.cfg_win, s_reg.cfg_ps};
                ADDR_CTRL_A: s_next.rdata = {2'b00, ps_raw, s_reg.soft_en};
                ADDR_CTRL_B: s_next.rdata = {1'b0, s_reg.rt_clk, 1'b0, s_reg.rt_win};
                ADDR_STATUS: s_next.rdata = {s_reg.cfg_mode, running, win_open, s_reg.armed, eighth};
                ADDR_FLAGS:  s_next.rdata = s_reg.flags;
                ADDR_MEM_VIOLATION_N:   s_next.rdata = {6'h00, s_reg.mem_ok, 1'b0};
                default:     s_next.rdata = 8'h00;
            endcase
        end else begin
            s_next.waitreq = 1'b1;
        end

        if (wr_fire) begin
            case (i_avs_address)
                ADDR_CFG: begin
                    s_next.cfg_win = i_avs_writedata[7:5];
                    s_next.cfg_ps = i_avs_writedata[4:0];
                    s_next.cfg_clk = i_avs_writedata[10:8];
                    s_next.cfg_mode = i_avs_writedata[12:11];
                end
                ADDR_CTRL_A: begin
                    // Prescale is read-only unless the config period defers to it
                    if (s_reg.cfg_ps == PS_ALL_ONES) begin
                        s_next.rt_ps = i_avs_writedata[5:1];
                    end
                    s_next.soft_en = i_avs_writedata[0];
                end
                ADDR_CTRL_B: begin
                    s_next.rt_clk = i_avs_writedata[6:4];
                    s_next.rt_win = i_avs_writedata[2:0];
                end
                ADDR_FLAGS: s_next.flags = i_avs_writedata[7:0];
                ADDR_MEM_VIOLATION_N:  s_next.mem_ok = i_avs_writedata[B_MEM_VIOLATION_N];
                default: ;
            endcase
        end
        if (rd_fire & i_avs_address == ADDR_CTRL_A) begin
            s_next.armed = 1'b1;
        end

        // Hardware events after firmware writes so they win a same-cycle clash
        if (i_evt.stack_over) begin
            s_next.flags[B_STK_OVF] = 1'b1;
        end
        if (i_evt.stack_under) begin
            s_next.flags[B_STK_UNF] = 1'b1;
        end
        if (i_evt.pin_reset) begin
            s_next.flags[B_PIN_RST] = 1'b0;
        end
        if (i_evt.soft_reset) begin
            s_next.flags[B_SOFT] = 1'b0;
        end
        if (i_evt.mem_violation) begin
            s_next.mem_ok = 1'b0;
        end
        if (i_evt.brown_out) begin
            s_next.flags[B_STK_OVF] = 1'b0;
            s_next.flags[B_STK_UNF] = 1'b0;
            s_next.flags[B_TIMEOUT] = 1'b1;
            s_next.flags[B_PIN_RST] = 1'b1;
            s_next.flags[B_SOFT] = 1'b1;
            s_next.flags[B_BROWN] = 1'b0;
            s_next.mem_ok = 1'b1;
        end
        if (i_evt.power_on) begin
            s_next.flags[B_STK_OVF] = 1'b0;
            s_next.flags[B_STK_UNF] = 1'b0;
            s_next.flags[B_WIN_VIO] = 1'b1;
            s_next.flags[B_TIMEOUT] = 1'b1;
            s_next.flags[B_PIN_RST] = 1'b1;
            s_next.flags[B_SOFT] = 1'b1;
            s_next.flags[B_POR] = 1'b0;
            s_next.mem_ok = 1'b1;
            s_next.to_n = 1'b1;
            s_next.pd_n = 1'b1;
        end

        if (violation) begin
            s_next.flags[B_WIN_VIO] = 1'b0;
        end
        if (timeout & ~i_evt.sleep) begin
            s_next.flags[B_TIMEOUT] = 1'b0;
            s_next.to_n = 1'b0;
        end
        if (timeout & i_evt.sleep) begin
            s_next.dog_wake = 1'b1;
            s_next.to_n = 1'b0;
            s_next.pd_n = 1'b0;
        end else if (sleep_rise) begin
            s_next.to_n = 1'b1;
            s_next.pd_n = 1'b0;
        end else if (valid_clear) begin
            s_next.to_n = 1'b1;
            s_next.pd_n = 1'b1;
        end
        s_next.dog_reset = own_reset;

        // Every reset returns the runtime prescale to the default period, or to the config period when that is not all ones
        if (own_reset | any_ext_reset) begin
            s_next.rt_ps = (s_next.cfg_ps == PS_ALL_ONES) ? PS_DEFAULT : s_next.cfg_ps;
            s_next.soft_en = 1'b0;
            s_next.rt_win = WIN_FULL;
            s_next.rt_clk = CFG_CLK_RST;
        end

        if (i_evt.dog_clear_instr) begin
            s_next.armed = 1'b0;
        end
        dog_clear = own_reset | any_ext_reset | valid_clear | sleep_rise | i_evt.wake_int
                  | ~running | i_evt.ost_running | ctrl_write | timeout;
        if (dog_clear) begin
            s_next.presc = 12'h000;
            s_next.cnt = 24'h000000;
        end else if (tick) begin
            s_next.presc = 12'h000;
            s_next.cnt = s_reg.cnt + 24'h000001;
        end else begin
            s_next.presc = s_reg.presc + 12'h001;
        end
        if (own_reset | any_ext_reset) begin
            s_next.armed = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_avs_readdata = {24'h000000, s_reg.rdata};
    assign o_avs_waitrequest = s_reg.waitreq;
    assign o_dog_reset = s_reg.dog_reset;
    assign o_dog_wake = s_reg.dog_wake;
    assign o_timeout_n = s_reg.to_n;
    assign o_powerdown_n = s_reg.pd_n;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    a_stack_over_set: assert property (i_evt.stack_over & ~i_evt.power_on & ~i_evt.brown_out
        |=> s_reg.flags[B_STK_OVF]) else $error("stack overflow flag not set");
    a_stack_under_set: assert property (i_evt.stack_under & ~i_evt.power_on & ~i_evt.brown_out
        |=> s_reg.flags[B_STK_UNF]) else $error("stack underflow flag not set");
    a_violation_resets: assert property (violation ##1 1'b1 |-> o_dog_reset && !s_reg.flags[B_WIN_VIO])
        else $error("window violation not reported");
    a_timeout_resets: assert property (timeout & ~i_evt.sleep
        |=> o_dog_reset && !s_reg.flags[B_TIMEOUT] && s_reg.cnt == 24'h000000)
        else $error("timeout did not reset");
    a_pin_flag_clear: assert property (i_evt.pin_reset & ~i_evt.brown_out & ~i_evt.power_on
        |=> !s_reg.flags[B_PIN_RST]) else $error("pin reset flag not cleared");
    a_soft_flag_clear: assert property (i_evt.soft_reset & ~i_evt.brown_out & ~i_evt.power_on
        |=> !s_reg.flags[B_SOFT]) else $error("soft reset flag not cleared");
    a_por_flag_clear: assert property (i_evt.power_on |=> !s_reg.flags[B_POR] && s_reg.mem_ok)
        else $error("power-on flags wrong");
    a_bor_flag_keep: assert property (i_evt.brown_out & ~i_evt.power_on & ~wr_fire
        |=> !s_reg.flags[B_BROWN] && s_reg.flags[B_POR] == $past(s_reg.flags[B_POR]))
        else $error("brown-out flags wrong");
    a_mem_flag_clear: assert property (i_evt.mem_violation & ~i_evt.power_on & ~i_evt.brown_out
        |=> !s_reg.mem_ok) else $error("memory violation flag not cleared");
    a_sleep_wakes: assert property (timeout & i_evt.sleep |=> o_dog_wake && !o_dog_reset && !o_powerdown_n)
        else $error("sleep timeout did not wake");
    a_disabled_idle: assert property (!running ##1 !running |-> s_reg.cnt == 24'h000000 && !o_dog_reset)
        else $error("disabled dog counted");
    a_clear_restarts: assert property (valid_clear |=> s_reg.cnt == 24'h000000 && s_reg.presc == 12'h000)
        else $error("clear did not restart");
    a_bus_one_wait: assert property ((i_avs_read | i_avs_write) & o_avs_waitrequest
        |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer timing wrong");

    c_timeout_reset: cover property (timeout & ~i_evt.sleep);
    c_window_violation: cover property (violation);
    c_windowed_clear: cover property (valid_clear & windowed & running);
    c_sleep_wake: cover property (timeout & i_evt.sleep);

endmodule // wwdrf_core

// >>> verification/wwdrf_cpu_model.sv
`timescale 1ns/1ns
// ************************************************************
// CPU side: turns bench requests into one-cycle event pulses
// ************************************************************
module wwdrf_cpu_model
    import wwdrf_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_go,
    input  wire wwdrf_evt_t i_req,
    input  wire logic       i_sleep,
    output wwdrf_evt_t      o_evt
);
    wwdrf_evt_t req_now;

    // Pulses last exactly one cycle; sleep is a level from the bench
    always_comb begin
        req_now       = i_go ? i_req : '0;
        req_now.sleep = i_sleep;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_evt <= '0;
        end else begin
            o_evt <= req_now;
        end
    end
endmodule // wwdrf_cpu_model

// >>> verification/tb_windowed_watchdog_reset_flags.sv
`timescale 1ns/1ns
module tb_windowed_watchdog_reset_flags;
    import wwdrf_pkg::*;
    logic        i_core_clk = 1'b0;
    logic        i_rst      = 1'b1;
    logic [13:0] adr        = 14'h0000;
    logic        rd         = 1'b0;
    logic        wr         = 1'b0;
    logic [31:0] wdat       = 32'h0;
    logic [3:0]  be         = 4'h1;
    logic        go         = 1'b0;
    logic        slp        = 1'b0;
    wwdrf_evt_t  req        = '0;
    wwdrf_evt_t  evt;
    logic [31:0] rdat;
    logic        wait_n, dog_rst, dog_wake, to_n, pd_n;
    logic [7:0]  q;
    int          bad_count  = 0;
    int          cmp_count  = 0;
    int          n;
    int          m;
    int          dog_cnt    = 0;
    int          ev_bit [5] = '{8, 7, 5, 10, 9};
    logic [7:0]  ev_exp [5] = '{8'hf7, 8'hf3, 8'h3e, 8'hbe, 8'hfe};

    initial begin
        forever #4 i_core_clk = ~i_core_clk;
    end

    wwdrf_core i_wwdrf_core (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be), .i_evt(evt), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wait_n), .o_dog_reset(dog_rst), .o_dog_wake(dog_wake), .o_timeout_n(to_n),
        .o_powerdown_n(pd_n));
    wwdrf_cpu_model i_wwdrf_cpu_model (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_go(go), .i_req(req),
        .i_sleep(slp), .o_evt(evt));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then idles one cycle
    task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d, input logic [3:0] b);
        adr  <= a;
        wr   <= w;
        rd   <= !w;
        wdat <= {24'h0, d};
        be   <= b;
        do begin
            @(posedge i_core_clk);
        end while (wait_n !== 1'b0);
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic pulse(input int bit_no);
        req <= wwdrf_evt_t'(11'h1 << bit_no);
        go  <= 1'b1;
        @(posedge i_core_clk);
        go  <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    endtask

    // Reset pulses are counted so that one seen inside pulse() is not lost
    always @(posedge i_core_clk) begin
        if (dog_rst === 1'b1) begin
            dog_cnt <= dog_cnt + 1;
        end
    end

    // Counts cycles until the pulse count leaves ref, giving up at lim
    task automatic wait_dog(input int ref_cnt, input int lim);
        n = 0;
        while (dog_cnt == ref_cnt && n < lim) begin
            @(posedge i_core_clk);
            n++;
        end
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        bus(0, ADDR_FLAGS, 8'h0, 4'h1);  chk(q, FLAGS_RST);
        bus(0, ADDR_MEM_VIOLATION_N, 8'h0, 4'h1);   chk(q, 8'h02);
        bus(0, ADDR_CTRL_B, 8'h0, 4'h1); chk(q, 8'h07);
        bus(0, 14'h0004, 8'h0, 4'h1);    chk(q, 8'h00);
        bus(1, ADDR_FLAGS, 8'hff, 4'h1);
        bus(0, ADDR_FLAGS, 8'h0, 4'h1);  chk(q, 8'hff);
        for (int i = 0; i < 5; i++) begin
            pulse(ev_bit[i]);
            bus(0, ADDR_FLAGS, 8'h0, 4'h1);
            chk(q, ev_exp[i]);
        end
        bus(1, ADDR_FLAGS, 8'h00, 4'h0);
        bus(0, ADDR_FLAGS, 8'h0, 4'h1);  chk(q, 8'hfe);
        bus(1, ADDR_FLAGS, 8'h00, 4'h1);
        bus(0, ADDR_FLAGS, 8'h0, 4'h1);  chk(q, 8'h00);
        pulse(6);
        bus(0, ADDR_FLAGS, 8'h0, 4'h1);  chk(q & 8'hfe, 8'h3c);
        pulse(4);
        bus(0, ADDR_MEM_VIOLATION_N, 8'h0, 4'h1);   chk(q, 8'h00);
        bus(1, ADDR_MEM_VIOLATION_N, 8'h02, 4'h1);
        bus(0, ADDR_MEM_VIOLATION_N, 8'h0, 4'h1);   chk(q, 8'h02);
        bus(1, ADDR_FLAGS, 8'hff, 4'h1);
        // Unwindowed clear while running must not reset
        bus(0, ADDR_CTRL_A, 8'h0, 4'h1); chk(q, 8'h16);
        m = dog_cnt;
        pulse(3);
        wait_dog(m, 20);                 chk(8'(n), 8'd20);
        // Half window, clear while closed and unarmed
        bus(1, ADDR_CTRL_B, 8'h03, 4'h1);
        m = dog_cnt;
        pulse(3);
        wait_dog(m, 10);                 chk(8'(n < 10), 8'h01);
        @(posedge i_core_clk);
        bus(0, ADDR_FLAGS, 8'h0, 4'h1);  chk(q, 8'hdf);
        bus(0, ADDR_CTRL_B, 8'h0, 4'h1); chk(q, 8'h07);
        // Shortest period: 32 ticks of the low oscillator
        m = dog_cnt;
        bus(1, ADDR_CTRL_A, 8'h00, 4'h1);
        wait_dog(m, 140000);
        chk(8'(n >= 129000 && n <= 129100), 8'h01);
        @(posedge i_core_clk);
        chk({7'h0, to_n}, 8'h00);
        bus(0, ADDR_FLAGS, 8'h0, 4'h1);  chk(q, 8'hcf);
        slp <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        chk({7'h0, pd_n}, 8'h00);
        chk({7'h0, dog_wake}, 8'h00);
        slp <= 1'b0;
        @(posedge i_core_clk);
        test_done();
    end

    initial begin
        repeat (300000) @(posedge i_core_clk);
        bad_count++;
        test_done();
    end
endmodule // tb_windowed_watchdog_reset_flags
